// ===== verilog/ppc_regs.vh
`ifndef PPC_REGS_VH
`define PPC_REGS_VH
// register offsets on the 8-bit address port
`define PPC_P0_INPUT_MODE_ADDR 8'h8F
`define PPC_P2_FUNC_PRI_ADDR 8'hF5
`define PPC_P1_INPUT_MODE_ADDR 8'hF6
`define PPC_PULL_SELECT_ADDR 8'hF7
`define PPC_P0_DIR_ADDR 8'hFD
`define PPC_P1_DIR_ADDR 8'hFE
`define PPC_P2_DIR_PRI_ADDR 8'hFF
// writable bit masks; all other bits ignore writes and read zero
`define PPC_P2_FUNC_PRI_MASK 8'h7F
`define PPC_P1_INPUT_MODE_MASK 8'hFC
`define PPC_PULL_SELECT_MASK 8'h60
`define PPC_P2_DIR_PRI_MASK 8'hDF
`define PPC_FULL_MASK 8'hFF
// reset values
`define PPC_RESET_VAL 8'h00
// field positions in the port 2 select register
`define PPC_PRI_USART_PAIR_BIT 6
`define PPC_PRI_USARTB_T3_BIT 5
`define PPC_PRI_T1_T4_BIT 4
`define PPC_PRI_USARTA_T1_BIT 3
`define PPC_PIN24_SEL_BIT 2
`define PPC_PIN23_SEL_BIT 1
`define PPC_PIN20_SEL_BIT 0
// field positions in the port 2 direction register
`define PPC_P0_PRI_HI 7
`define PPC_P0_PRI_LO 6
`define PPC_P2_DIR_HI 4
// pull select bits (pull-down when set)
`define PPC_PULL_P1_BIT 6
`define PPC_PULL_P0_BIT 5
// port 0 precedence field codes
`define PPC_P0PRI_A_OVER_B 2'h0
`define PPC_P0PRI_B_OVER_A 2'h1
`define PPC_P0PRI_T1_OVER_B 2'h2
`define PPC_P0PRI_T1_OVER_A 2'h3
`endif

// ===== verilog/ppc_top.v
`timescale 1ns/10ps
// Overview of operation
// [R01] usart pair on port 1: bit 6 picks
// [R02] usart b versus timer 3: bit 5 picks
// [R03] timer 1 versus timer 4: bit 4 picks
// [R04] usart a versus timer 1: bit 3 picks
// [R05] bits 2..0 select peripheral on P2_4/3/0
// [R06] port 0/1 direction bits, reset to inputs
// [R07] port 2 direction low five bits, reset inputs
// [R08] port 0 field 00/01 ranks the usarts
// [R09] port 0 field 10/11 ranks timer 1
// [R10] port 0 mode: pulled or tristate, reset pulled
// [R11] port 1 mode bits 7..2 only, rest zero
// [R12] per-port pull-up or pull-down select bit
// [R13] unused bits ignore writes, read zero
`include "ppc_regs.vh"
module ppc_top (
	input wire mclk, // system clock, 10 MHz
	input wire rst, // asynchronous reset, active high
	input wire [7:0] addr, // register address
	input wire [7:0] wdata, // register write data
	input wire wr, // write strobe
	input wire rd, // read strobe
	output reg [7:0] rdata, // read data, cycle after rd
	input wire p0_usarta_on, // serial_unit_a mapped onto port 0
	input wire p0_usartb_on, // serial_unit_b mapped onto port 0
	input wire p0_timer1_on, // timer 1 mapped onto port 0
	input wire p1_usarta_on, // serial_unit_a mapped onto port 1
	input wire p1_usartb_on, // serial_unit_b mapped onto port 1
	input wire p1_timer1_on, // timer 1 mapped onto port 1
	input wire p1_timer3_on, // timer 3 mapped onto port 1
	input wire p1_timer4_on, // timer 4 mapped onto port 1
	output reg p0_usarta_grant, // serial_unit_a owns its port 0 pins
	output reg p0_usartb_grant, // serial_unit_b owns its port 0 pins
	output reg p0_timer1_grant, // timer 1 owns its port 0 pins
	output reg p1_usarta_grant, // serial_unit_a owns its port 1 pins
	output reg p1_usartb_grant, // serial_unit_b owns its port 1 pins
	output reg p1_timer1_grant, // timer 1 owns its port 1 pins
	output reg p1_timer3_grant, // timer 3 owns its port 1 pins
	output reg p1_timer4_grant, // timer 4 owns its port 1 pins
	output reg [7:0] port0_oe, // port 0 pin is an output
	output reg [7:0] port1_oe, // port 1 pin is an output
	output reg [4:0] port2_oe, // port 2 pin is an output
	output reg [2:0] port2_periph_sel, // P2_4, P2_3, P2_0 peripheral select
	output reg [7:0] port0_pull_en, // port 0 input pull active
	output reg [7:0] port1_pull_en, // port 1 input pull active
	output reg port0_pull_down, // port 0 pulls down, else up
	output reg port1_pull_down // port 1 pulls down, else up
);

////////////////////////////////////////////////////////////////////////
// registers

reg [7:0] port0_input_mode_r;
reg [7:0] port2_function_select_priority_r;
reg [7:0] port1_input_mode_r;
reg [7:0] port_pull_select_r;
reg [7:0] port0_direction_r;
reg [7:0] port1_direction_r;
reg [7:0] port2_direction_priority_r;

// one decode per register; unmapped addresses hit nothing
wire hit_p0_mode = (addr == `PPC_P0_INPUT_MODE_ADDR);
wire hit_p2_sel = (addr == `PPC_P2_FUNC_PRI_ADDR);
wire hit_p1_mode = (addr == `PPC_P1_INPUT_MODE_ADDR);
wire hit_pull = (addr == `PPC_PULL_SELECT_ADDR);
wire hit_p0_dir = (addr == `PPC_P0_DIR_ADDR);
wire hit_p1_dir = (addr == `PPC_P1_DIR_ADDR);
wire hit_p2_dir = (addr == `PPC_P2_DIR_PRI_ADDR);

// port 0 input mode, every bit writable
always @(posedge mclk or posedge rst) begin
	if (rst) begin
		port0_input_mode_r <= `PPC_RESET_VAL; // [R10]
	end else if (wr && hit_p0_mode) begin
		port0_input_mode_r <= wdata & `PPC_FULL_MASK; // [R10]
	end
end

// port 2 select and port 1 precedence; bit 7 stays zero
always @(posedge mclk or posedge rst) begin
	if (rst) begin
		port2_function_select_priority_r <= `PPC_RESET_VAL; // [R05]
	end else if (wr && hit_p2_sel) begin
		port2_function_select_priority_r <= wdata & `PPC_P2_FUNC_PRI_MASK; // [R13]
	end
end

// port 1 input mode; the two low pins have no pull, so no mode
always @(posedge mclk or posedge rst) begin
	if (rst) begin
		port1_input_mode_r <= `PPC_RESET_VAL; // [R11]
	end else if (wr && hit_p1_mode) begin
		port1_input_mode_r <= wdata & `PPC_P1_INPUT_MODE_MASK; // [R11]
	end
end

// pull direction bits for ports 0 and 1 only
always @(posedge mclk or posedge rst) begin
	if (rst) begin
		port_pull_select_r <= `PPC_RESET_VAL; // [R12]
	end else if (wr && hit_pull) begin
		port_pull_select_r <= wdata & `PPC_PULL_SELECT_MASK; // [R12]
	end
end

// port 0 direction, every bit writable
always @(posedge mclk or posedge rst) begin
	if (rst) begin
		port0_direction_r <= `PPC_RESET_VAL; // [R06]
	end else if (wr && hit_p0_dir) begin
		port0_direction_r <= wdata & `PPC_FULL_MASK; // [R06]
	end
end

// port 1 direction, every bit writable
always @(posedge mclk or posedge rst) begin
	if (rst) begin
		port1_direction_r <= `PPC_RESET_VAL; // [R06]
	end else if (wr && hit_p1_dir) begin
		port1_direction_r <= wdata & `PPC_FULL_MASK; // [R06]
	end
end

// port 2 direction and port 0 precedence; bit 5 stays zero
always @(posedge mclk or posedge rst) begin
	if (rst) begin
		port2_direction_priority_r <= `PPC_RESET_VAL; // [R07] [R08]
	end else if (wr && hit_p2_dir) begin
		port2_direction_priority_r <= wdata & `PPC_P2_DIR_PRI_MASK; // [R13]
	end
end

////////////////////////////////////////////////////////////////////////
// read path, data one cycle after the strobe, zero otherwise

reg [7:0] rdata_nxt;

always @* begin
	rdata_nxt = 8'h00;
	if (rd) begin
		case (addr)
			`PPC_P0_INPUT_MODE_ADDR: rdata_nxt = port0_input_mode_r;
			`PPC_P2_FUNC_PRI_ADDR: rdata_nxt = port2_function_select_priority_r;
			`PPC_P1_INPUT_MODE_ADDR: rdata_nxt = port1_input_mode_r; // [R11]
			`PPC_PULL_SELECT_ADDR: rdata_nxt = port_pull_select_r;
			`PPC_P0_DIR_ADDR: rdata_nxt = port0_direction_r;
			`PPC_P1_DIR_ADDR: rdata_nxt = port1_direction_r;
			`PPC_P2_DIR_PRI_ADDR: rdata_nxt = port2_direction_priority_r;
			default: rdata_nxt = 8'h00;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////
// precedence resolution

// port 1 precedence bits of the port 2 select register
wire p1_usart_pair_precedence =
	port2_function_select_priority_r[`PPC_PRI_USART_PAIR_BIT]; // [R01]
wire p1_usartb_timer3_precedence =
	port2_function_select_priority_r[`PPC_PRI_USARTB_T3_BIT]; // [R02]
wire p1_timer1_timer4_precedence =
	port2_function_select_priority_r[`PPC_PRI_T1_T4_BIT]; // [R03]
wire p1_usarta_timer1_precedence =
	port2_function_select_priority_r[`PPC_PRI_USARTA_T1_BIT]; // [R04]

// port 2 pins that may carry a peripheral function
wire pin24_function_sel = port2_function_select_priority_r[`PPC_PIN24_SEL_BIT]; // [R05]
wire pin23_function_sel = port2_function_select_priority_r[`PPC_PIN23_SEL_BIT]; // [R05]
wire pin20_function_sel = port2_function_select_priority_r[`PPC_PIN20_SEL_BIT]; // [R05]

// direction fields, a set bit makes the pin an output
wire [7:0] port0_pin_direction = port0_direction_r; // [R06]
wire [7:0] port1_pin_direction = port1_direction_r; // [R06]
wire [4:0] port2_pin_direction = port2_direction_priority_r[`PPC_P2_DIR_HI:0]; // [R07]
wire [1:0] port0_precedence_field =
	port2_direction_priority_r[`PPC_P0_PRI_HI:`PPC_P0_PRI_LO]; // [R08] [R09]

// input mode fields, a set bit makes the pin tristate
wire [7:0] port0_input_mode_bits = port0_input_mode_r; // [R10]
wire [7:0] port1_input_mode_bits = port1_input_mode_r & `PPC_P1_INPUT_MODE_MASK; // [R11]

// pull direction, one select per port, set pulls down
wire port0_pull_direction = port_pull_select_r[`PPC_PULL_P0_BIT]; // [R12]
wire port1_pull_direction = port_pull_select_r[`PPC_PULL_P1_BIT]; // [R12]

// a pin pulls only while it is an input in pulled mode
wire [7:0] port0_pulled = ~port0_input_mode_bits & ~port0_pin_direction; // [R10]
wire [7:0] port1_pulled = ~port1_input_mode_bits & ~port1_pin_direction
	& `PPC_P1_INPUT_MODE_MASK; // [R11]

// port 0 field decoded once
wire p0_code_ab = (port0_precedence_field == `PPC_P0PRI_A_OVER_B); // [R08]
wire p0_code_ba = (port0_precedence_field == `PPC_P0PRI_B_OVER_A); // [R08]
wire p0_code_tb = (port0_precedence_field == `PPC_P0PRI_T1_OVER_B); // [R09]
wire p0_code_ta = (port0_precedence_field == `PPC_P0PRI_T1_OVER_A); // [R09]

// port 1: high when the first named is mapped and ranks above the second
wire p1_b_over_a = p1_usartb_on & p1_usart_pair_precedence; // [R01]
wire p1_a_over_b = p1_usarta_on & ~p1_usart_pair_precedence; // [R01]
wire p1_t3_over_b = p1_timer3_on & p1_usartb_timer3_precedence; // [R02]
wire p1_b_over_t3 = p1_usartb_on & ~p1_usartb_timer3_precedence; // [R02]
wire p1_t4_over_t1 = p1_timer4_on & p1_timer1_timer4_precedence; // [R03]
wire p1_t1_over_t4 = p1_timer1_on & ~p1_timer1_timer4_precedence; // [R03]
wire p1_t1_over_a = p1_timer1_on & p1_usarta_timer1_precedence; // [R04]
wire p1_a_over_t1 = p1_usarta_on & ~p1_usarta_timer1_precedence; // [R04]

// port 0: timer 1 loses to any usart the field does not rank below it
wire p0_b_over_a = p0_usartb_on & p0_code_ba; // [R08]
wire p0_a_over_b = p0_usarta_on & p0_code_ab; // [R08]
wire p0_t1_over_b = p0_timer1_on & p0_code_tb; // [R09]
wire p0_t1_over_a = p0_timer1_on & p0_code_ta; // [R09]
wire p0_b_over_t1 = p0_usartb_on & ~p0_code_tb; // [R09]
wire p0_a_over_t1 = p0_usarta_on & ~p0_code_ta; // [R09]

reg g0a_nxt, g0b_nxt, g0t1_nxt;
reg g1a_nxt, g1b_nxt, g1t1_nxt, g1t3_nxt, g1t4_nxt;

// port 1 grants: mapped and outranked by no present rival
always @* begin
	g1a_nxt = p1_usarta_on & ~p1_b_over_a & ~p1_t1_over_a; // [R01] [R04]
	g1b_nxt = p1_usartb_on & ~p1_a_over_b & ~p1_t3_over_b; // [R01] [R02]
	g1t3_nxt = p1_timer3_on & ~p1_b_over_t3; // [R02]
	g1t1_nxt = p1_timer1_on & ~p1_t4_over_t1 & ~p1_a_over_t1; // [R03] [R04]
	g1t4_nxt = p1_timer4_on & ~p1_t1_over_t4; // [R03]
end

// port 0 grants; a usart pair under a timer code is left to software
always @* begin
	g0a_nxt = p0_usarta_on & ~p0_b_over_a & ~p0_t1_over_a; // [R08] [R09]
	g0b_nxt = p0_usartb_on & ~p0_a_over_b & ~p0_t1_over_b; // [R08] [R09]
	g0t1_nxt = p0_timer1_on & ~p0_b_over_t1 & ~p0_a_over_t1; // [R09]
end

////////////////////////////////////////////////////////////////////////
// registered pin controls

// read data stands for one cycle only
always @(posedge mclk or posedge rst) begin
	if (rst) begin
		rdata <= 8'h00;
	end else begin
		rdata <= rdata_nxt; // [R13]
	end
end

// port 0 grants, one cycle behind the claims
always @(posedge mclk or posedge rst) begin
	if (rst) begin
		p0_usarta_grant <= 1'b0;
		p0_usartb_grant <= 1'b0;
		p0_timer1_grant <= 1'b0;
	end else begin
		p0_usarta_grant <= g0a_nxt; // [R08]
		p0_usartb_grant <= g0b_nxt; // [R08]
		p0_timer1_grant <= g0t1_nxt; // [R09]
	end
end

// port 1 grants, one cycle behind the claims
always @(posedge mclk or posedge rst) begin
	if (rst) begin
		p1_usarta_grant <= 1'b0;
		p1_usartb_grant <= 1'b0;
		p1_timer1_grant <= 1'b0;
		p1_timer3_grant <= 1'b0;
		p1_timer4_grant <= 1'b0;
	end else begin
		p1_usarta_grant <= g1a_nxt; // [R01]
		p1_usartb_grant <= g1b_nxt; // [R02]
		p1_timer1_grant <= g1t1_nxt; // [R03]
		p1_timer3_grant <= g1t3_nxt; // [R02]
		p1_timer4_grant <= g1t4_nxt; // [R03]
	end
end

// registered pin directions
always @(posedge mclk or posedge rst) begin
	if (rst) begin
		port0_oe <= 8'h00;
		port1_oe <= 8'h00;
		port2_oe <= 5'h00;
	end else begin
		port0_oe <= port0_pin_direction; // [R06]
		port1_oe <= port1_pin_direction; // [R06]
		port2_oe <= port2_pin_direction; // [R07]
	end
end

// registered port 2 function select
always @(posedge mclk or posedge rst) begin
	if (rst) begin
		port2_periph_sel <= 3'h0;
	end else begin
		port2_periph_sel <= {pin24_function_sel, pin23_function_sel, pin20_function_sel}; // [R05]
	end
end

// registered pull controls
always @(posedge mclk or posedge rst) begin
	if (rst) begin
		port0_pull_en <= 8'h00;
		port1_pull_en <= 8'h00;
		port0_pull_down <= 1'b0;
		port1_pull_down <= 1'b0;
	end else begin
		port0_pull_en <= port0_pulled; // [R10]
		port1_pull_en <= port1_pulled; // [R11]
		port0_pull_down <= port0_pull_direction; // [R12]
		port1_pull_down <= port1_pull_direction; // [R12]
	end
end

endmodule

// ===== tb/ppc_checker.sv
`timescale 1ns/10ps
module ppc_checker (
	input wire mclk, rst, wr, rd, // clock, reset, strobes
	input wire [7:0] addr, wdata, rdata, // register bus
	input wire p0_usarta_on, p0_usartb_on, p0_timer1_on, // port 0 map
	input wire p1_usarta_on, p1_usartb_on, p1_timer1_on, p1_timer3_on, p1_timer4_on, // map
	input wire p0_usarta_grant, p0_usartb_grant, p0_timer1_grant, // port 0 owners
	input wire p1_usarta_grant, p1_usartb_grant, p1_timer1_grant, // port 1 owners
	input wire p1_timer3_grant, p1_timer4_grant, // port 1 owners
	input wire [7:0] port0_oe, port1_pull_en, // pin controls
	input wire [2:0] port2_periph_sel // port 2 select
);
	// claim and grant vectors, a first
	wire [4:0] p1on = {p1_usarta_on, p1_usartb_on, p1_timer1_on, p1_timer3_on, p1_timer4_on};
	wire [4:0] g1 = {p1_usarta_grant, p1_usartb_grant, p1_timer1_grant, p1_timer3_grant,
		p1_timer4_grant};
	wire [2:0] p0on = {p0_usarta_on, p0_usartb_on, p0_timer1_on};
	wire [2:0] g0 = {p0_usarta_grant, p0_usartb_grant, p0_timer1_grant};
	reg [7:0] sel_r;
	reg [1:0] pri_r;
	// shadow of the select register and the port 0 field
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			sel_r <= 8'h00;
			pri_r <= 2'h0;
		end else if (wr && addr == 8'hF5) begin
			sel_r <= wdata;
		end else if (wr && addr == 8'hFF) begin
			pri_r <= wdata[7:6];
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	AST_RD_IDLE: assert property (!rd |=> rdata == 8'h00)
		else $error("rdata without read");
	AST_U_PAIR: assert property (p1on == 5'h18
		|=> g1 == ($past(sel_r[6]) ? 5'h08 : 5'h10)) else $error("usart pair owner");
	AST_UB_T3: assert property (p1on == 5'h0A
		|=> g1 == ($past(sel_r[5]) ? 5'h02 : 5'h08)) else $error("usart b timer 3 owner");
	AST_T1_T4: assert property (p1on == 5'h05
		|=> g1 == ($past(sel_r[4]) ? 5'h01 : 5'h04)) else $error("timer 1 timer 4 owner");
	AST_UA_T1: assert property (p1on == 5'h14
		|=> g1 == ($past(sel_r[3]) ? 5'h04 : 5'h10)) else $error("usart a timer 1 owner");
	AST_P0_AB: assert property (p0on == 3'h6 && !pri_r[1]
		|=> g0 == ($past(pri_r[0]) ? 3'h2 : 3'h4)) else $error("port 0 usart owner");
	AST_P0_T1: assert property ((p0on == 3'h3 && pri_r == 2'h2)
		|| (p0on == 3'h5 && pri_r == 2'h3) |=> g0 == 3'h1) else $error("port 0 timer owner");
	AST_PIN_SEL: assert property (port2_periph_sel == $past(sel_r[2:0]))
		else $error("port 2 select");
	AST_OE_P0: assert property (wr && addr == 8'hFD |-> ##2 port0_oe == $past(wdata, 2))
		else $error("port 0 direction");
	AST_PULL_LOW: assert property (port1_pull_en[1:0] == 2'h0)
		else $error("port 1 low pulls");
	// main scenarios seen
	cover property (p1on == 5'h18);
	cover property (p0on == 3'h5 && pri_r == 2'h3);
	cover property (wr && addr == 8'hFD);
endmodule

// ===== tb/ppc_periph_model.sv
`timescale 1ns/10ps
// peripherals claiming pins; a claim moves only just after an edge
module ppc_periph_model (
	input wire mclk, // system clock
	input wire [7:0] map, // wanted claims {p0 a,b,t1, p1 a,b,t1,t3,t4}
	output reg [7:0] pin_on = 8'h00 // claims seen by the port logic
);
	// claims follow the location setting one cycle later
	always @(posedge mclk) begin
		pin_on <= map;
	end
endmodule

// ===== tb/ppc_top_tb.sv
`timescale 1ns/10ps
module ppc_top_tb;
	reg mclk, rst, wr, rd;
	reg [7:0] addr, wdata, map;
	wire [7:0] rdata, pin_on, gnt, port0_oe, port1_oe, port0_pull_en, port1_pull_en;
	wire [4:0] port2_oe;
	wire [2:0] port2_periph_sel;
	wire port0_pull_down, port1_pull_down;
	integer fail_count = 0, num_checks = 0, cyc = 0, i;
	// register offsets and their readable masks
	reg [55:0] adrs = 56'h8FF5F6F7FDFEFF;
	reg [55:0] msks = 56'hFF7FFC60FFFFDF;
	ppc_periph_model i_ppc_periph_model (.mclk(mclk), .map(map), .pin_on(pin_on));
	ppc_top i_ppc_top (.mclk, .rst, .addr, .wdata, .wr, .rd, .rdata,
		.p0_usarta_on(pin_on[7]), .p0_usartb_on(pin_on[6]), .p0_timer1_on(pin_on[5]),
		.p1_usarta_on(pin_on[4]), .p1_usartb_on(pin_on[3]), .p1_timer1_on(pin_on[2]),
		.p1_timer3_on(pin_on[1]), .p1_timer4_on(pin_on[0]),
		.p0_usarta_grant(gnt[7]), .p0_usartb_grant(gnt[6]), .p0_timer1_grant(gnt[5]),
		.p1_usarta_grant(gnt[4]), .p1_usartb_grant(gnt[3]), .p1_timer1_grant(gnt[2]),
		.p1_timer3_grant(gnt[1]), .p1_timer4_grant(gnt[0]), .port0_oe, .port1_oe,
		.port2_oe, .port2_periph_sel, .port0_pull_en, .port1_pull_en, .port0_pull_down,
		.port1_pull_down);
	// clock and hang guard
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc = cyc + 1;
		if (cyc == 2000) begin
			fail_count = fail_count + 1;
			summarize;
		end
	end
	task chk(input [7:0] g, input [7:0] e);
		begin
			num_checks = num_checks + 1;
			if (g !== e) begin
				fail_count = fail_count + 1;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
			end
		end
	endtask
	task wr_reg(input [7:0] a, input [7:0] d);
		begin
			@(posedge mclk);
			addr <= a;
			wdata <= d;
			wr <= 1'b1;
			@(posedge mclk);
			wr <= 1'b0;
		end
	endtask
	task rd_chk(input [7:0] a, input [7:0] e);
		begin
			@(posedge mclk);
			addr <= a;
			rd <= 1'b1;
			@(posedge mclk);
			rd <= 1'b0;
			#1 chk(rdata, e);
		end
	endtask
	task t_reset;
		begin
			for (i = 0; i < 7; i = i + 1) rd_chk(adrs[8*i +: 8], 8'h00);
			rd_chk(8'h80, 8'h00);
			chk({port2_oe, port2_periph_sel}, 8'h00);
			$display("reset test done");
		end
	endtask
	task t_mask;
		begin
			for (i = 0; i < 7; i = i + 1) wr_reg(adrs[8*i +: 8], 8'hFF);
			wr_reg(8'h80, 8'hFF);
			for (i = 0; i < 7; i = i + 1) rd_chk(adrs[8*i +: 8], msks[8*i +: 8]);
			rd_chk(8'h80, 8'h00);
			chk({port2_oe, port2_periph_sel}, 8'hFF);
			chk(port0_pull_en, 8'h00);
			chk({6'h00, port0_pull_down, port1_pull_down}, 8'h03);
			$display("mask test done");
		end
	endtask
	task t_pull;
		begin
			wr_reg(8'hFD, 8'h0F);
			wr_reg(8'h8F, 8'h30);
			wr_reg(8'hFE, 8'h00);
			wr_reg(8'hF6, 8'h00);
			wr_reg(8'hF7, 8'h20);
			wr_reg(8'hF5, 8'h04);
			wr_reg(8'hFF, 8'h01);
			repeat (2) @(posedge mclk);
			#1 chk(port0_pull_en, 8'hC0);
			chk(port1_pull_en, 8'hFC);
			chk(port1_oe, 8'h00);
			chk({6'h00, port0_pull_down, port1_pull_down}, 8'h02);
			chk({port2_oe, port2_periph_sel}, 8'h0C);
			$display("pull test done");
		end
	endtask
	task gr(input [7:0] m, input [7:0] f5, input [7:0] ff, input [7:0] e);
		begin
			wr_reg(8'hF5, f5);
			wr_reg(8'hFF, ff);
			@(posedge mclk);
			map <= m;
			repeat (3) @(posedge mclk);
			#1 chk(gnt, e);
		end
	endtask
	task t_prio;
		begin
			gr(8'h18, 8'h00, 8'h00, 8'h10);
			gr(8'h18, 8'h40, 8'h00, 8'h08);
			gr(8'h0A, 8'h00, 8'h00, 8'h08);
			gr(8'h0A, 8'h20, 8'h00, 8'h02);
			gr(8'h05, 8'h00, 8'h00, 8'h04);
			gr(8'h05, 8'h10, 8'h00, 8'h01);
			gr(8'h14, 8'h00, 8'h00, 8'h10);
			gr(8'h14, 8'h08, 8'h00, 8'h04);
			gr(8'hC0, 8'h00, 8'h00, 8'h80);
			gr(8'hC0, 8'h00, 8'h40, 8'h40);
			gr(8'h60, 8'h00, 8'h80, 8'h20);
			gr(8'hA0, 8'h00, 8'hC0, 8'h20);
			$display("priority test done");
		end
	endtask
	task summarize;
		begin
			$display("checks %0d mismatches %0d", num_checks, fail_count);
			if (fail_count == 0 && num_checks > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	// main sequence
	initial begin
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		map = 8'h00;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		t_reset;
		t_mask;
		t_pull;
		t_prio;
		summarize;
	end
endmodule
bind ppc_top ppc_checker i_ppc_checker (.mclk, .rst, .wr, .rd, .addr, .wdata, .rdata,
	.p0_usarta_on, .p0_usartb_on, .p0_timer1_on, .p1_usarta_on, .p1_usartb_on,
	.p1_timer1_on, .p1_timer3_on, .p1_timer4_on, .p0_usarta_grant, .p0_usartb_grant,
	.p0_timer1_grant, .p1_usarta_grant, .p1_usartb_grant, .p1_timer1_grant,
	.p1_timer3_grant, .p1_timer4_grant, .port0_oe, .port1_pull_en, .port2_periph_sel);
